// ==== ufbg_consts.vh ====
// Constants for the two-channel UART with fractional rate divider.
// Assumes an Avalon-MM slave with 32-bit data and byte addresses.
`ifndef UFBG_CONSTS_VH
`define UFBG_CONSTS_VH

`define UFBG_ADDR_W        10
`define UFBG_CH_BASE0      10'h000
`define UFBG_CH_BASE1      10'h200
`define UFBG_CH_SEL_BIT    9

// Register indices within a channel; byte address is base + 4 * index
`define UFBG_IDX_HOLDING   4'h0
`define UFBG_IDX_DIV_LOW   4'h0
`define UFBG_IDX_DIV_HIGH  4'h1
`define UFBG_IDX_DIV_FRAC  4'h2
`define UFBG_IDX_LINE_CTL  4'h3
`define UFBG_IDX_MODEM_CTL 4'h4
`define UFBG_IDX_STATUS    4'h5
`define UFBG_IDX_SAMPLING  4'h8

// Field positions
`define UFBG_LCR_DIV_ACCESS 7
`define UFBG_MCR_PRESCALE   7
`define UFBG_SMP_EIGHT      0
`define UFBG_SMP_FOUR       1
`define UFBG_ST_RX_AVAIL    0
`define UFBG_ST_OVERRUN     1
`define UFBG_ST_TX_ROOM     5
`define UFBG_ST_TX_IDLE     6

// Reset values
`define UFBG_RST_DIV_LOW   8'h01
`define UFBG_RST_DIV_HIGH  8'h00
`define UFBG_RST_DIV_FRAC  4'h0
`define UFBG_RST_LINE_CTL  8'h00
`define UFBG_RST_MODEM_CTL 8'h00
`define UFBG_RST_SAMPLING  2'h0

// Prescaler and sampling ratios (last count of each)
`define UFBG_PRESCALE_LAST 2'h3
`define UFBG_RATIO16_LAST  4'hF
`define UFBG_RATIO8_LAST   4'h7
`define UFBG_RATIO4_LAST   4'h3

// Channel FIFO geometry
`define UFBG_FIFO_W        8
`define UFBG_FIFO_DEPTH    256
`define UFBG_FIFO_AW       8

`endif

// ==== ufbg_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two equal to 2**AW.
module ufbg_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 256,
   parameter AW    = 8
) (
   input  wire             clk,
   input  wire             resetn,
   input  wire             inValid,
   output wire             inReady,
   input  wire [WIDTH-1:0] inData,
   output wire             outValid,
   input  wire             outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wrPtr;
   reg [AW-1:0]    rdPtr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;

   assign inReady  = (count != DEPTH);
   assign outValid = (count != 0);
   assign outData  = mem[rdPtr];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // ufbg_fifo

// ==== ufbg_rate_divider.v ====
// Prescaler and fractional divider producing the sampling tick.
// Assumes divisor fields are stable or may change between periods.
`include "ufbg_consts.vh"
module ufbg_rate_divider (
   input  wire        clk,
   input  wire        resetn,
   input  wire        prescaleBy4,
   input  wire [15:0] divInt,
   input  wire [3:0]  divFrac,
   output reg         sampleTick
);
   reg  [1:0]  preCnt;
   reg  [16:0] divCnt;
   reg  [3:0]  fracAcc;
   wire        preTick;
   wire [4:0]  fracSum;
   wire [16:0] periodLast;
   wire [15:0] intSafe;

   assign preTick = prescaleBy4 ? (preCnt == `UFBG_PRESCALE_LAST) : 1'b1; // [RULE5]
   // Stretch this period by one prescaled cycle when the accumulator carries [RULE16]
   assign fracSum = {1'b0, fracAcc} + {1'b0, divFrac}; // [RULE11]
   // A zero integer divisor is treated as one to keep the tick alive
   assign intSafe = (divInt == 16'h0000) ? 16'h0001 : divInt;
   assign periodLast = {1'b0, intSafe} + {16'h0000, fracSum[4]} - 17'h00001; // [RULE6]

   always @(posedge clk) begin
      if (!resetn) begin
         preCnt     <= 2'h0;
         divCnt     <= 17'h00000;
         fracAcc    <= 4'h0;
         sampleTick <= 1'b0;
      end else begin
         preCnt     <= prescaleBy4 ? preCnt + 2'h1 : 2'h0;
         sampleTick <= 1'b0;
         if (preTick) begin
            if (divCnt >= periodLast) begin
               divCnt     <= 17'h00000;
               fracAcc    <= fracSum[3:0]; // [RULE16]
               sampleTick <= 1'b1; // [RULE7]
            end else begin
               divCnt <= divCnt + 17'h00001;
            end
         end
      end
   end
endmodule // ufbg_rate_divider

// ==== ufbg_uart.v ====
// Two-channel UART core: registers, rate dividers, FIFOs, 8N1 shifters.
// Assumes an Avalon-MM master with 32-bit data; holding access is byte 0.
//
// Register access over Avalon-MM was left to the implementer.
`include "ufbg_consts.vh"

// Summary of operation
// RULE1: A byte written to a channel's transmit holding location enters its transmit FIFO, channel 0 at 0x0000 and channel 1 at 0x0200.
// RULE2: Reading a receive holding location returns the next received byte and removes it from that FIFO.
// RULE3: Software reaches the holding locations only with single-byte accesses.
// RULE4: Two independent channels, each with 256-byte transmit and receive FIFOs and its own rate divider.
// RULE5: The prescaler divides the core clock by 1 with modem control bit 7 clear and by 4 with it set.
// RULE6: The rate divider divides the prescaled clock by 1 up to 2^16 minus 1/16 in 1/16 steps.
// RULE7: The divided clock is the 16x, 8x or 4x sampling clock used to shift and sample serial bits.
// RULE8: After reset the divisor is 1: low byte 0x01, high byte and fraction 0x00.
// RULE9: The two divisor bytes give the integer part and the fraction register the fractional part.
// RULE10: The high divisor byte forms bits 15 to 8 and the low byte bits 7 to 0 of the integer divisor.
// RULE11: Only the low four fraction bits exist, adding 0 to 15/16 in sixteenths.
// RULE12: Ratio is 16 with both selects clear, 8 with only the 8x select and 4 with only the 4x select.
// RULE13: In 8x or 4x mode an odd fraction may jitter a bit time by up to 1/16.
// RULE14: Software programs the fraction as the rounded fractional divisor part times sixteen.
// RULE15: Divisor low, high and fraction registers are reachable only with line control bit 7 set, fraction at index 2.
// RULE16: The fraction is made by stretching chosen sampling periods one prescaled cycle, averaging right over sixteen.
// RULE17: Upper four fraction bits read as zero and ignore writes.
module ufbg_uart (
   input  wire                   clk,
   input  wire                   resetn,
   input  wire [`UFBG_ADDR_W-1:0] address,
   input  wire                   read,
   input  wire                   write,
   input  wire [3:0]             byteenable,
   input  wire [31:0]            writedata,
   output reg  [31:0]            readdata,
   output wire                   waitrequest,
   input  wire [1:0]             rxd,
   output wire [1:0]             txd
);
   wire       request;
   wire       fire;
   wire [1:0] chStall;
   wire [15:0] chRead;
   wire [3:0] regIdx;
   reg        ack;

   assign request     = read | write;
   assign fire        = request & ack;
   assign waitrequest = request & ~ack;
   assign regIdx      = address[5:2];

   // One wait cycle per access; a full transmit FIFO holds the write off
   always @(posedge clk) begin
      if (!resetn) begin
         ack      <= 1'b0;
         readdata <= 32'h00000000;
      end else begin
         ack <= request & ~ack & ~(|chStall);
         if (read && !ack) begin
            readdata <= {24'h000000,
                         address[`UFBG_CH_SEL_BIT] ? chRead[15:8]
                                                   : chRead[7:0]};
         end
      end
   end

   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : gCh // [RULE4]
         localparam [0:0] CH = (c == 1);
         wire       hit;
         wire       divAccess;
         wire       holdHit;
         wire       txPush;
         wire       txReady;
         wire       txValid;
         wire [7:0] txData;
         wire       rxValid;
         wire [7:0] rxData;
         wire       rxReady;
         wire       rxPop;
         wire       sampleTick;
         wire [15:0] divInt;
         wire [3:0] ratioLast;
         wire       statusRead;
         reg  [7:0] divLow;
         reg  [7:0] divHigh;
         reg  [3:0] divFrac;
         reg  [7:0] lineCtl;
         reg  [7:0] modemCtl;
         reg  [1:0] sampling;
         reg        overrun;
         reg  [7:0] readVal;
         reg        txBusy;
         reg  [3:0] txSub;
         reg  [3:0] txBits;
         reg  [9:0] txShift;
         reg        rxBusy;
         reg  [3:0] rxSub;
         reg  [3:0] rxBits;
         reg  [7:0] rxShift;
         reg        rxPush;

         assign hit       = (address[`UFBG_CH_SEL_BIT] == CH) &&
                            (address[8:6] == 3'h0);
         assign divAccess = lineCtl[`UFBG_LCR_DIV_ACCESS]; // [RULE15]
         assign holdHit   = hit && (regIdx == `UFBG_IDX_HOLDING) &&
                            !divAccess && byteenable[0]; // [RULE3]
         assign txPush    = write & fire & holdHit; // [RULE1]
         assign rxPop     = read & fire & holdHit & rxValid; // [RULE2]
         assign chStall[c] = write & holdHit & ~txReady;
         assign statusRead = read & fire & hit &
                             (regIdx == `UFBG_IDX_STATUS);
         assign divInt    = {divHigh, divLow}; // [RULE9] [RULE10]
         // Both selects set is undefined; it falls back to 16x
         assign ratioLast =
            (sampling == 2'b01) ? `UFBG_RATIO8_LAST : // [RULE13]
            (sampling == 2'b10) ? `UFBG_RATIO4_LAST :
                                  `UFBG_RATIO16_LAST; // [RULE12]

         always @(posedge clk) begin
            if (!resetn) begin
               divLow   <= `UFBG_RST_DIV_LOW; // [RULE8]
               divHigh  <= `UFBG_RST_DIV_HIGH;
               divFrac  <= `UFBG_RST_DIV_FRAC;
               lineCtl  <= `UFBG_RST_LINE_CTL;
               modemCtl <= `UFBG_RST_MODEM_CTL;
               sampling <= `UFBG_RST_SAMPLING;
            end else if (write && fire && hit && byteenable[0]) begin
               case (regIdx)
                  `UFBG_IDX_DIV_LOW: begin
                     if (divAccess) begin
                        divLow <= writedata[7:0]; // [RULE15]
                     end
                  end
                  `UFBG_IDX_DIV_HIGH: begin
                     if (divAccess) begin
                        divHigh <= writedata[7:0];
                     end
                  end
                  `UFBG_IDX_DIV_FRAC: begin
                     if (divAccess) begin
                        divFrac <= writedata[3:0]; // [RULE17]
                     end
                  end
                  `UFBG_IDX_LINE_CTL: begin
                     lineCtl <= writedata[7:0];
                  end
                  `UFBG_IDX_MODEM_CTL: begin
                     modemCtl <= writedata[7:0];
                  end
                  `UFBG_IDX_SAMPLING: begin
                     sampling <= writedata[1:0];
                  end
                  default: begin
                     lineCtl <= lineCtl;
                  end
               endcase
            end
         end

         always @* begin
            readVal = 8'h00;
            if (hit) begin
               case (regIdx)
                  `UFBG_IDX_HOLDING: begin
                     if (divAccess) begin
                        readVal = divLow;
                     end else if (rxValid) begin
                        readVal = rxData; // [RULE2]
                     end
                  end
                  `UFBG_IDX_DIV_HIGH: begin
                     readVal = divAccess ? divHigh : 8'h00;
                  end
                  `UFBG_IDX_DIV_FRAC: begin
                     readVal = divAccess ? {4'h0, divFrac} : 8'h00; // [RULE17]
                  end
                  `UFBG_IDX_LINE_CTL: begin
                     readVal = lineCtl;
                  end
                  `UFBG_IDX_MODEM_CTL: begin
                     readVal = modemCtl;
                  end
                  `UFBG_IDX_STATUS: begin
                     readVal[`UFBG_ST_RX_AVAIL] = rxValid;
                     readVal[`UFBG_ST_OVERRUN]  = overrun;
                     readVal[`UFBG_ST_TX_ROOM]  = txReady;
                     readVal[`UFBG_ST_TX_IDLE]  = ~txBusy & ~txValid;
                  end
                  `UFBG_IDX_SAMPLING: begin
                     readVal = {6'h00, sampling};
                  end
                  default: begin
                     readVal = 8'h00;
                  end
               endcase
            end
         end
         assign chRead[8*c+7:8*c] = readVal;

         ufbg_rate_divider uDiv (
            .clk         (clk),
            .resetn      (resetn),
            .prescaleBy4 (modemCtl[`UFBG_MCR_PRESCALE]), // [RULE5]
            .divInt      (divInt),
            .divFrac     (divFrac),
            .sampleTick  (sampleTick)
         );

         ufbg_fifo #(
            .WIDTH (`UFBG_FIFO_W),
            .DEPTH (`UFBG_FIFO_DEPTH),
            .AW    (`UFBG_FIFO_AW)
         ) uTxFifo (
            .clk      (clk),
            .resetn   (resetn),
            .inValid  (txPush),
            .inReady  (txReady),
            .inData   (writedata[7:0]),
            .outValid (txValid),
            .outReady (~txBusy),
            .outData  (txData)
         );

         ufbg_fifo #(
            .WIDTH (`UFBG_FIFO_W),
            .DEPTH (`UFBG_FIFO_DEPTH),
            .AW    (`UFBG_FIFO_AW)
         ) uRxFifo (
            .clk      (clk),
            .resetn   (resetn),
            .inValid  (rxPush),
            .inReady  (rxReady),
            .inData   (rxShift),
            .outValid (rxValid),
            .outReady (rxPop),
            .outData  (rxData)
         );

         // Transmitter: start, 8 data bits LSB first, stop
         always @(posedge clk) begin
            if (!resetn) begin
               txBusy  <= 1'b0;
               txSub   <= 4'h0;
               txBits  <= 4'h0;
               txShift <= 10'h3FF;
            end else if (!txBusy) begin
               if (txValid) begin
                  txBusy  <= 1'b1;
                  txSub   <= 4'h0;
                  txBits  <= 4'h0;
                  txShift <= {1'b1, txData, 1'b0};
               end
            end else if (sampleTick) begin // [RULE7]
               if (txSub >= ratioLast) begin
                  txSub   <= 4'h0;
                  txShift <= {1'b1, txShift[9:1]};
                  txBits  <= txBits + 4'h1;
                  if (txBits == 4'h9) begin
                     txBusy <= 1'b0;
                  end
               end else begin
                  txSub <= txSub + 4'h1;
               end
            end
         end
         assign txd[c] = txShift[0];

         // Receiver: start bit checked at half a bit, then one per bit
         always @(posedge clk) begin
            if (!resetn) begin
               rxBusy  <= 1'b0;
               rxSub   <= 4'h0;
               rxBits  <= 4'h0;
               rxShift <= 8'h00;
               rxPush  <= 1'b0;
            end else begin
               rxPush <= 1'b0;
               if (sampleTick) begin // [RULE7]
                  if (!rxBusy) begin
                     if (!rxd[c]) begin
                        rxBusy <= 1'b1;
                        rxSub  <= 4'h0;
                        rxBits <= 4'h0;
                     end
                  end else if ((rxBits == 4'h0) ?
                               (rxSub >= {1'b0, ratioLast[3:1]}) :
                               (rxSub >= ratioLast)) begin
                     rxSub  <= 4'h0;
                     rxBits <= rxBits + 4'h1;
                     if (rxBits == 4'h0) begin
                        rxBusy <= ~rxd[c];
                     end else if (rxBits == 4'h9) begin
                        rxBusy <= 1'b0;
                        rxPush <= rxd[c];
                     end else begin
                        rxShift <= {rxd[c], rxShift[7:1]};
                     end
                  end else begin
                     rxSub <= rxSub + 4'h1;
                  end
               end
            end
         end

         // Lost byte flag; a new loss in the clearing cycle wins
         always @(posedge clk) begin
            if (!resetn) begin
               overrun <= 1'b0;
            end else if (rxPush && !rxReady) begin
               overrun <= 1'b1;
            end else if (statusRead) begin
               overrun <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // ufbg_uart

// ==== ufbg_uart_monitor.sv ====
// Checker for the register bus and serial outputs of ufbg_uart.
// Sees only the top module's ports; attached by bind below.
module ufbg_uart_monitor (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic [31:0] readdata,
   input wire logic [1:0]  txd
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_idle_no_wait: assert property (
      !read && !write |-> !waitrequest)
      else $error("waitrequest high without a request");
   a_new_req_waits: assert property (
      (read || write) && !$past(read || write) |-> waitrequest)
      else $error("new request not stalled one cycle");
   a_read_one_wait: assert property (
      read && waitrequest |=> !waitrequest)
      else $error("read answer late");
   a_read_byte_lane: assert property (
      read && !waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("read data above the low byte");
   a_data_stands: assert property (
      !(read && waitrequest) |=> $stable(readdata))
      else $error("readdata changed outside a read");
   a_start_len_ch0: assert property (
      $fell(txd[0]) |-> (!txd[0])[*4])
      else $error("channel 0 start bit too short");
   a_start_len_ch1: assert property (
      $fell(txd[1]) |-> (!txd[1])[*4])
      else $error("channel 1 start bit too short");
   a_idle_after_rst: assert property (
      $rose(resetn) |-> txd == 2'h3)
      else $error("serial outputs not idle after reset");

   cover property (read && !waitrequest);
   cover property (write && !waitrequest);
   cover property ($fell(txd[1]));
endmodule // ufbg_uart_monitor

bind ufbg_uart ufbg_uart_monitor ufbg_uart_monitor_inst (
   .clk         (clk),
   .resetn      (resetn),
   .read        (read),
   .write       (write),
   .waitrequest (waitrequest),
   .readdata    (readdata),
   .txd         (txd)
);

// ==== ufbg_serial_peer.sv ====
// Far-end serial station for one channel: 8N1, LSB first.
// Assumes bitClks holds the current bit time in clk cycles.
module ufbg_serial_peer (
   input  wire logic clk,
   input  wire logic txLine,
   input  var  int   bitClks,
   output logic      rxLine,
   output logic      got,
   output logic [7:0] gotByte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   initial begin
      rxLine = 1'b1;
      got = 1'b0;
   end

   // Mid-bit sampling tolerates the unaligned first bit
   always begin
      @(negedge txLine);
      repeat (bitClks / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bitClks) @(posedge clk);
         sh[i] = txLine;
      end
      repeat (bitClks) @(posedge clk);
      gotByte <= sh;
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
   end

   // Line idles high between frames
   task automatic send(input logic [7:0] d);
      rxLine <= 1'b0;
      repeat (bitClks) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxLine <= d[i];
         repeat (bitClks) @(posedge clk);
      end
      rxLine <= 1'b1;
      repeat (bitClks) @(posedge clk);
   endtask
endmodule // ufbg_serial_peer

// ==== tb_top.sv ====
// Self-checking bench for the two-channel UART.
// Assumes ufbg_uart, ufbg_serial_peer and the bound checker.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [9:0]  address = 10'h000;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic        waitrequest;
   wire  [1:0]  rxd;
   logic [1:0]  txd;
   wire  [1:0]  got;
   logic [7:0]  gotByte [2];
   int          bitCk [2] = '{16, 16};
   int          error_cnt = 0;
   int          compares = 0;
   logic [7:0]  txQ [2][$];
   logic [31:0] rdQ [$];
   logic [7:0]  b;
   logic [7:0]  b1;
   // Columns: modem ctl, divisor low, fraction, sampling, bit clocks
   logic [7:0]  tbl [3][5] = '{'{8'h00, 8'h02, 8'h08, 8'h02, 8'h0A},
                               '{8'h80, 8'h01, 8'h00, 8'h01, 8'h20},
                               '{8'h00, 8'h01, 8'h04, 8'h00, 8'h14}};

   always #5 clk = ~clk;

   ufbg_uart ufbg_uart_inst (
      .clk         (clk),
      .resetn      (resetn),
      .address     (address),
      .read        (read),
      .write       (write),
      .byteenable  (byteenable),
      .writedata   (writedata),
      .readdata    (readdata),
      .waitrequest (waitrequest),
      .rxd         (rxd),
      .txd         (txd)
   );

   for (genvar c = 0; c < 2; c++) begin : peer
      ufbg_serial_peer ufbg_serial_peer_inst (
         .clk     (clk),
         .txLine  (txd[c]),
         .bitClks (bitCk[c]),
         .rxLine  (rxd[c]),
         .got     (got[c]),
         .gotByte (gotByte[c])
      );
   end

   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
      end
   endtask

   task automatic cmp_ser(input int c, input logic [7:0] g,
                          input logic [7:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t line %0d got %h expected %h",
                  $time, c, g, e);
      end
   endtask

   // Watches results and takes the oldest note for each
   always @(posedge clk) begin
      if (read && !waitrequest && rdQ.size() > 0)
         cmp_rd(readdata, rdQ.pop_front());
      for (int c = 0; c < 2; c++)
         if (got[c] === 1'b1)
            cmp_ser(c, gotByte[c],
                    txQ[c].size() ? txQ[c].pop_front() : 8'hXX);
   end

   task automatic wr(input int ch, input logic [3:0] i, input logic [7:0] d);
      @(posedge clk);
      address <= {ch[0], 3'b000, i, 2'b00};
      writedata <= {24'h000000, d};
      byteenable <= 4'h1;
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask

   task automatic rd(input int ch, input logic [3:0] i, input logic [31:0] e);
      rdQ.push_back(e);
      @(posedge clk);
      address <= {ch[0], 3'b000, i, 2'b00};
      byteenable <= 4'h1;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
   endtask

   task automatic drain;
      for (int n = 0; n < 8000; n++)
         if (txQ[0].size() + txQ[1].size() != 0) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask

   task automatic finish_test;
      // A result that never arrived must not let the run pass
      if (txQ[0].size() + txQ[1].size() + rdQ.size() != 0) begin
         error_cnt++;
         $display("CHECK FAILED %0t expected results missing", $time);
      end
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      finish_test;
   end

   initial begin
      void'($urandom(32'h3c9fd6e9));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      wr(0, 4'h3, 8'h80);
      rd(0, 4'h0, 32'h01);
      rd(0, 4'h1, 32'h00);
      rd(0, 4'h2, 32'h00);
      wr(0, 4'h2, 8'hFF);
      rd(0, 4'h2, 32'h0F);
      b = 8'($urandom);
      wr(0, 4'h1, b);
      rd(0, 4'h1, {24'h000000, b});
      wr(0, 4'h1, 8'h00);
      wr(0, 4'h2, 8'h00);
      rd(0, 4'h7, 32'h00);
      wr(0, 4'h3, 8'h00);
      rd(0, 4'h1, 32'h00);
      $display("test registers done");
      for (int ch = 0; ch < 2; ch++)
         for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            txQ[ch].push_back(b);
            wr(ch, 4'h0, b);
         end
      drain;
      $display("test transmit done");
      b = 8'($urandom);
      b1 = 8'($urandom);
      fork
         peer[0].ufbg_serial_peer_inst.send(b);
         peer[1].ufbg_serial_peer_inst.send(b1);
      join
      repeat (2) @(posedge clk);
      rd(0, 4'h0, {24'h000000, b});
      rd(1, 4'h0, {24'h000000, b1});
      rd(1, 4'h0, 32'h00);
      rd(1, 4'h5, 32'h60);
      $display("test receive done");
      // Divisor, prescale and ratio combinations on channel 0
      for (int i = 0; i < 3; i++) begin
         wr(0, 4'h3, 8'h80);
         wr(0, 4'h0, tbl[i][1]);
         wr(0, 4'h2, tbl[i][2]);
         wr(0, 4'h3, 8'h00);
         wr(0, 4'h4, tbl[i][0]);
         wr(0, 4'h8, tbl[i][3]);
         bitCk[0] = int'(tbl[i][4]);
         b = 8'($urandom);
         txQ[0].push_back(b);
         wr(0, 4'h0, b);
         drain;
      end
      $display("test rates done");
      finish_test;
   end
endmodule // tb_top
